// [strap_pkg.sv]
// constants and types for the repeater strap and general pin block
// Summary of operation
// - register-bus mode: interrupt pin open-drain, held low while interrupt pending.
// - other modes: interrupt pin is a strap input sampled at reset.
// - after reset in register-bus mode the interrupt pin works as open-drain output only.
// - uart-select and debug pins are inputs after reset and soft reset.
// - register-bus mode: uart-select pin low enables sideband uart mode.
// - uart mode routes usb d+ to eusb2 d+, eusb2 d- to usb d-.
// - register-bus mode: debug pin is a debug input.
// - plain repeater mode: uart-select and debug pins are straps sampled at reset; uart mode: uart-select low enables uart.
// - plain repeater mode: three pin straps form the tuning code.
// - after reset release the repeater enables in default eusb2 mode.
package strap_pkg;
   localparam int unsigned SYNC_STAGES = 3;
   localparam logic [2:0] TUNE_RESET = 3'h0;
   // cycles after release before straps are captured
   localparam int unsigned SETTLE_CYCLES = 4;
   localparam int unsigned SETTLE_W = 3;

   typedef enum logic [1:0] {
      MODE_REPEATER = 2'b00,
      MODE_UART = 2'b01,
      MODE_REGBUS = 2'b10
   } mode_type;

   typedef struct packed {
      logic scl;
      logic sda;
      logic uart_select_pin;
      logic debug_strap_pin;
      logic irq_strap_pin;
   } pins_type;

   typedef struct packed {
      logic usb_dp_to_edp;
      logic edn_to_usb_dn;
   } uart_route_type;
endpackage

// [strap_pins.sv]
// strap sampling, mode select and general pin roles of the repeater
`timescale 1ns/100ps
`default_nettype none
module strap_pins (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire strap_pkg::pins_type pins_i,
   input wire logic soft_reset_i,
   input wire logic irq_pending_i,
   input wire logic usb_dp_i,
   input wire logic edn_i,
   output logic irq_strap_pin_o,
   output logic irq_strap_pin_oe_o,
   output logic uart_select_pin_oe_o,
   output logic debug_strap_pin_oe_o,
   output strap_pkg::mode_type mode_o,
   output logic straps_valid_o,
   output logic [2:0] tune_code_o,
   output logic uart_enable_o,
   output logic debug_in_o,
   output logic repeater_enable_o,
   output logic edp_o,
   output logic usb_dn_o,
   output strap_pkg::uart_route_type route_o
);
   import strap_pkg::*;

   // three-stage synchronisers for the pins
   pins_type s1_q, s2_q, s3_q;
   pins_type s1_d, s2_d, s3_d;
   logic [SETTLE_W-1:0] cnt_q, cnt_d;
   logic valid_q, valid_d;
   mode_type mode_q, mode_d;
   logic [2:0] tune_q, tune_d;
   logic uart_en_q, uart_en_d;
   logic dbg_q, dbg_d;
   logic irq_q, irq_d;
   logic edp_q, edp_d;
   logic dn_q, dn_d;

   always_comb begin
      s1_d = pins_i;
      s2_d = s1_q;
      s3_d = s2_q;
      cnt_d = cnt_q;
      valid_d = valid_q;
      mode_d = mode_q;
      tune_d = tune_q;
      uart_en_d = uart_en_q;
      dbg_d = dbg_q;
      irq_d = 1'b0;
      edp_d = 1'b0;
      dn_d = 1'b0;
      if (!valid_q) begin
         // sample straps once settled and stable
         if (cnt_q != SETTLE_W'(SETTLE_CYCLES)) begin
            cnt_d = cnt_q + SETTLE_W'(1);
         end else if (s2_q == s3_q) begin
            valid_d = 1'b1;
            if (!s3_q.scl) begin
               mode_d = MODE_REPEATER;
               tune_d = {s3_q.irq_strap_pin, s3_q.debug_strap_pin, s3_q.uart_select_pin};
            end else if (!s3_q.sda) begin
               mode_d = MODE_UART;
            end else begin
               mode_d = MODE_REGBUS;
            end
         end
      end else begin
         if (s2_q.uart_select_pin == s3_q.uart_select_pin) begin
            uart_en_d = (mode_q != MODE_REPEATER) && !s3_q.uart_select_pin;
         end
         if (s2_q.debug_strap_pin == s3_q.debug_strap_pin) begin
            dbg_d = (mode_q == MODE_REGBUS) && s3_q.debug_strap_pin;
         end
         irq_d = (mode_q == MODE_REGBUS) && irq_pending_i;
         edp_d = uart_en_q && usb_dp_i;
         dn_d = uart_en_q && edn_i;
      end
      if (soft_reset_i) begin
         uart_en_d = 1'b0;
         dbg_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         cnt_q <= '0;
         valid_q <= 1'b0;
         mode_q <= MODE_REPEATER;
         tune_q <= TUNE_RESET;
         uart_en_q <= 1'b0;
         dbg_q <= 1'b0;
         irq_q <= 1'b0;
         edp_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         cnt_q <= cnt_d;
         valid_q <= valid_d;
         mode_q <= mode_d;
         tune_q <= tune_d;
         uart_en_q <= uart_en_d;
         dbg_q <= dbg_d;
         irq_q <= irq_d;
         edp_q <= edp_d;
         dn_q <= dn_d;
      end
   end

   // open-drain: output always low, enable only when asserting
   assign irq_strap_pin_o = 1'b0;
   assign irq_strap_pin_oe_o = irq_q;
   assign uart_select_pin_oe_o = 1'b0;
   assign debug_strap_pin_oe_o = 1'b0;
   assign mode_o = mode_q;
   assign straps_valid_o = valid_q;
   assign tune_code_o = tune_q;
   assign uart_enable_o = uart_en_q;
   assign debug_in_o = dbg_q;
   assign repeater_enable_o = valid_q;
   assign edp_o = edp_q;
   assign usb_dn_o = dn_q;
   assign route_o = '{usb_dp_to_edp: uart_en_q, edn_to_usb_dn: uart_en_q};
endmodule // strap_pins
`default_nettype wire

// [host_model.sv]
// host and strap resistor model
`timescale 1ns/100ps
`default_nettype none
module host_model import strap_pkg::*; (
   input wire pins_type cfg_i,
   input wire logic irq_oe_i,
   output pins_type pins_o
);
   assign pins_o = {cfg_i[4:1], cfg_i[0] & !irq_oe_i};
endmodule // host_model
`default_nettype wire

// [strap_pins_properties.sv]
// checker of the strap pin block
`timescale 1ns/100ps
`default_nettype none
module strap_pins_properties import strap_pkg::*; (
   input wire logic clk_i, rst_n_i, soft_reset_i, irq_pending_i, usb_dp_i, edp_o, debug_in_o,
   input wire logic straps_valid_o, uart_enable_o, irq_strap_pin_oe_o,
   input wire logic repeater_enable_o,
   input wire pins_type pins_i,
   input wire mode_type mode_o,
   input wire logic [2:0] tune_code_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   irq_lvl_a: assert property (irq_pending_i && straps_valid_o && mode_o == MODE_REGBUS |=> irq_strap_pin_oe_o)
      else $error("irq");
   irq_off_a: assert property (mode_o != MODE_REGBUS |-> !irq_strap_pin_oe_o) else $error("oe");
   soft_clr_a: assert property (soft_reset_i |=> !uart_enable_o && !debug_in_o) else $error("soft");
   uart_on_a: assert property ((straps_valid_o && !pins_i[2] && !soft_reset_i) [*6] ##0 mode_o != 2'h0 |-> uart_enable_o)
      else $error("uart on");
   uart_off_a: assert property (pins_i[2] [*5] |-> !uart_enable_o) else $error("uart off");
   uart_dir_a: assert property ($past(uart_enable_o) && uart_enable_o |-> edp_o == $past(usb_dp_i)) else $error("dir");
   mode_sel_a: assert property ($rose(straps_valid_o) |-> mode_o == (pins_i[4] ? {pins_i[3], !pins_i[3]} : 2'h0))
      else $error("mode");
   tune_cap_a: assert property ($rose(straps_valid_o) && mode_o == 2'h0 |-> tune_code_o == {pins_i[0], pins_i[1], pins_i[2]})
      else $error("tune");
   rep_enable_a: assert property (repeater_enable_o == straps_valid_o) else $error("repeater enable");
   c_irq: cover property (irq_strap_pin_oe_o);
   c_uart: cover property (uart_enable_o && edp_o);
   c_soft: cover property (soft_reset_i && uart_enable_o);
endmodule // strap_pins_properties
bind strap_pins strap_pins_properties i_chk (.*);
`default_nettype wire

// [tb.sv]
// bench of the strap pin block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import strap_pkg::*;
   logic clk_i = 0, rst_n_i = 0, soft_reset_i = 0, irq_pending_i = 0, usb_dp_i = 0, edn_i = 0;
   logic irq_strap_pin_o, irq_strap_pin_oe_o, uart_select_pin_oe_o, debug_strap_pin_oe_o, straps_valid_o;
   logic uart_enable_o, debug_in_o, repeater_enable_o, edp_o, usb_dn_o;
   logic [2:0] tune_code_o;
   mode_type mode_o;
   uart_route_type route_o;
   pins_type cfg = '0, pins_i;
   int fail_count = 0, num_checks = 0;
   host_model i_host (.cfg_i(cfg), .irq_oe_i(irq_strap_pin_oe_o), .pins_o(pins_i));
   strap_pins i_dut (.*);
   initial forever #2.5 clk_i = ~clk_i;
   task chk(input logic [4:0] s, e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t %h %h", $time, s, e);
      end
   endtask
   task final_report;
      $display("checks %0d fails %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task boot(input pins_type p);
      rst_n_i = 0;
      cfg = p;
      repeat (20) @(negedge clk_i);
      rst_n_i = 1;
      repeat (9) @(negedge clk_i);
   endtask
   initial begin
      boot(5'h06);
      chk({mode_o, tune_code_o}, 5'h03);
      cfg.scl = 1;
      repeat (9) @(negedge clk_i);
      chk({mode_o, repeater_enable_o, uart_enable_o}, 5'h02);
      boot(5'h10);
      {usb_dp_i, edn_i} = 2'b11;
      @(negedge clk_i);
      chk({mode_o, edp_o, usb_dn_o, irq_strap_pin_oe_o}, 5'h0E);
      chk({route_o, straps_valid_o, debug_strap_pin_oe_o, irq_strap_pin_o}, 5'h1C);
      cfg.uart_select_pin = 1;
      repeat (5) @(negedge clk_i);
      chk(uart_enable_o, 1'b0);
      chk({route_o, edp_o, usb_dn_o}, 5'h00);
      boot(5'h1F);
      irq_pending_i = 1;
      repeat (2) @(negedge clk_i);
      chk({mode_o, debug_in_o, uart_enable_o, pins_i.irq_strap_pin}, 5'h14);
      chk({irq_strap_pin_o, debug_strap_pin_oe_o, irq_strap_pin_oe_o}, 5'h01);
      irq_pending_i = 0;
      cfg.uart_select_pin = 0;
      repeat (6) @(negedge clk_i);
      chk({pins_i.irq_strap_pin, uart_enable_o}, 5'h03);
      soft_reset_i = 1;
      @(negedge clk_i);
      chk({uart_enable_o, debug_in_o, uart_select_pin_oe_o}, 5'h00);
      final_report;
   end
   initial begin
      repeat (400) @(posedge clk_i);
      fail_count++;
      final_report;
   end
endmodule // tb
`default_nettype wire
